// ### rtl/vic_top.v
// vectored interrupt controller top: APB registers, flags, proximity hold, presentation
//
// Functional notes
// RULE1 - rank pending events before CPU presentation
// RULE2 - sixty-four sources with flag and enable
// RULE3 - sources map onto forty-four vectors
// RULE4 - single-vector and multi-vector presentation
// RULE5 - five external inputs, selectable edge each
// RULE6 - three-bit priority per vector
// RULE7 - two-bit subpriority breaks equal priority
// RULE8 - software writing a flag raises it
// RULE9 - vector table base is programmable
// RULE10 - vector spacing is programmable
// RULE11 - full tie favours lower request number
// RULE12 - requests split across low and high words
// RULE13 - four vectors per priority word
// RULE14 - capture error and capture share vector
// RULE15 - serial unit requests share one vector
// RULE16 - two-wire and port-change requests grouped
// RULE17 - external inputs at fixed requests/vectors
// RULE18 - persistent sources reassert while condition holds
// RULE19 - channel requests 60-63 to vectors 40-43
// RULE20 - no shadow set signalled
// RULE21 - control bit selects multi-vector mode
// RULE22 - proximity field starts holdoff timer
// RULE23 - polarity bit: 1 rising, 0 falling
// RULE24 - status shows latest vector and level
// RULE25 - zero priority never presented
// RULE26 - flag stays until software clears
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`include "vic_consts.vh"
module vic_top #(
  parameter NSRC = `VIC_NUM_SOURCES,
  parameter NEXT = `VIC_NUM_EXT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NSRC-1:0] src_event,
  input wire [NEXT-1:0] external_irq,
  output reg irq_req,
  output reg [5:0] irq_vector,
  output reg [2:0] irq_level,
  output reg [31:0] irq_handler_addr
);

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_HOLD = 2'd1;
  localparam ST_SHOW = 2'd2;

  reg [1:0] state;
  reg [31:0] control;
  reg [31:0] prox_reload;
  reg [31:0] prox_count;
  reg [31:0] pending_flags_low;
  reg [31:0] pending_flags_high;
  reg [31:0] source_enables_low;
  reg [31:0] source_enables_high;
  reg [31:0] vector_priority [0:`VIC_NUM_PRIO_WORDS-1];
  reg [31:0] vector_table;
  reg [15:0] vector_spacing;
  reg [5:0] presented_vector;
  reg [2:0] presented_level;

  wire [NEXT-1:0] ext_edge;
  wire found;
  wire [5:0] win_vector;
  wire [2:0] win_level;
  wire [1:0] win_sub;
  wire [351:0] prio_flat;
  reg [63:0] hw_set;

  wire multi_vector_select = control[`VIC_CTL_MULTI_BIT]; // [RULE21]
  wire [2:0] proximity_threshold = control[`VIC_CTL_PROX_HI:`VIC_CTL_PROX_LO];
  wire [NEXT-1:0] ext_irq_polarity = control[NEXT-1:0];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // one wait state: pready rises in the second access cycle, writes land there
  wire apb_access = psel & penable;
  // misaligned offsets only raise slverr, so they must never write a register
  wire wr_en = apb_access & pready & pwrite & (paddr[1:0] == 2'b00);
  wire prio_hit = (paddr >= `VIC_OFF_PRIO_BASE) && (paddr <= `VIC_OFF_PRIO_LAST);
  wire [3:0] prio_idx = paddr[5:2] - 4'd12;

  // ----------------------------------------
  // external pins
  // ----------------------------------------
  // each pin has its own polarity bit in the control word
  vic_edge_detect #(
    .N(NEXT)
  ) u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(external_irq),
    .rising_sel(ext_irq_polarity),
    .edge_pulse(ext_edge)
  ); // [RULE5]

  // ----------------------------------------
  // hardware set terms
  // ----------------------------------------
  // external requests take fixed slots; level sources keep setting while high
  always @* begin
    hw_set = src_event;
    hw_set[3] = ext_edge[0]; // [RULE17]
    hw_set[8] = ext_edge[1];
    hw_set[13] = ext_edge[2];
    hw_set[18] = ext_edge[3];
    hw_set[23] = ext_edge[4];
  end

  // ----------------------------------------
  // priority words and ranking
  // ----------------------------------------
  genvar k;
  generate
    for (k = 0; k < `VIC_NUM_PRIO_WORDS; k = k + 1) begin : g_prio
      assign prio_flat[k*32 +: 32] = vector_priority[k];
    end
  endgenerate

  // lower word holds requests 0..31, upper word 32..63
  vic_arbiter u_arb (
    .pending({pending_flags_high, pending_flags_low}), // [RULE12]
    .enable({source_enables_high, source_enables_low}),
    .prio_flat(prio_flat),
    .found(found),
    .win_vector(win_vector),
    .win_level(win_level),
    .win_sub(win_sub)
  );

  // ----------------------------------------
  // pending flags and enables
  // ----------------------------------------
  // a hardware set in the same cycle as a software clear wins, so no event is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_flags_low <= `VIC_RESET_WORD;
      pending_flags_high <= `VIC_RESET_WORD;
    end else begin
      if (wr_en && paddr == `VIC_OFF_FLAGS_LOW) begin
        pending_flags_low <= pwdata | hw_set[31:0]; // [RULE8]
      end else begin
        pending_flags_low <= pending_flags_low | hw_set[31:0]; // [RULE26]
      end
      if (wr_en && paddr == `VIC_OFF_FLAGS_HIGH) begin
        pending_flags_high <= pwdata | hw_set[63:32]; // [RULE18]
      end else begin
        pending_flags_high <= pending_flags_high | hw_set[63:32]; // [RULE2]
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // unused priority bits are dropped so they read back as zero
  integer w;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= `VIC_RESET_WORD;
      prox_reload <= `VIC_RESET_WORD;
      source_enables_low <= `VIC_RESET_WORD;
      source_enables_high <= `VIC_RESET_WORD;
      vector_table <= `VIC_RESET_WORD;
      vector_spacing <= `VIC_RESET_SPACING;
      for (w = 0; w < `VIC_NUM_PRIO_WORDS; w = w + 1) begin
        vector_priority[w] <= `VIC_RESET_WORD;
      end
    end else if (wr_en) begin
      case (paddr)
        `VIC_OFF_CONTROL: begin
          control <= pwdata & 32'h0000_171F; // no shadow-set bit is kept [RULE20]
        end
        `VIC_OFF_PROX_RELOAD: begin
          prox_reload <= pwdata;
        end
        `VIC_OFF_ENABLES_LOW: begin
          source_enables_low <= pwdata;
        end
        `VIC_OFF_ENABLES_HIGH: begin
          source_enables_high <= pwdata;
        end
        `VIC_OFF_TABLE_BASE: begin
          vector_table <= pwdata; // [RULE9]
        end
        `VIC_OFF_SPACING: begin
          vector_spacing <= pwdata[15:0]; // [RULE10]
        end
        default: begin
          if (prio_hit) begin
            vector_priority[prio_idx] <= pwdata & `VIC_PRIO_FIELD_MASK;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // proximity hold and presentation
  // ----------------------------------------
  // a winner at or below the threshold waits out the reload count first,
  // which batches low-priority bursts; threshold zero bypasses the wait
  wire [31:0] handler_offset = {26'd0, win_vector} * {16'd0, vector_spacing};
  wire prox_hit = (proximity_threshold != 3'd0) && (win_level <= proximity_threshold);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      prox_count <= `VIC_RESET_WORD;
      irq_req <= 1'b0;
      irq_vector <= 6'd0;
      irq_level <= 3'd0;
      irq_handler_addr <= `VIC_RESET_WORD;
      presented_vector <= 6'd0;
      presented_level <= 3'd0;
    end else begin
      case (state)
        ST_IDLE: begin
          irq_req <= 1'b0;
          if (found && prox_hit && prox_reload != 32'h0000_0000) begin
            prox_count <= prox_reload; // [RULE22]
            state <= ST_HOLD;
          end else if (found) begin
            state <= ST_SHOW;
          end
        end
        ST_HOLD: begin
          if (!found) begin
            prox_count <= 32'h0000_0000;
            state <= ST_IDLE;
          end else if (prox_count <= 32'h0000_0001 || !prox_hit) begin
            prox_count <= 32'h0000_0000;
            state <= ST_SHOW;
          end else begin
            prox_count <= prox_count - 32'h0000_0001;
          end
        end
        ST_SHOW: begin
          // track the current winner each cycle so a higher arrival pre-empts
          if (found) begin
            irq_req <= 1'b1;
            irq_level <= win_level;
            presented_vector <= win_vector; // [RULE24]
            presented_level <= win_level;
            if (multi_vector_select) begin
              irq_vector <= win_vector; // [RULE4]
              irq_handler_addr <= vector_table + handler_offset;
            end else begin
              irq_vector <= 6'd0;
              irq_handler_addr <= vector_table;
            end
          end else begin
            irq_req <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // APB response
  // ----------------------------------------
  // read data is registered with pready; unmapped offsets read zero and flag slverr
  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `VIC_OFF_CONTROL: rd_mux = control;
      `VIC_OFF_STATUS: rd_mux = {21'd0, presented_level, 2'd0, presented_vector};
      `VIC_OFF_PROX_RELOAD: rd_mux = prox_reload;
      `VIC_OFF_PROX_COUNT: rd_mux = prox_count;
      `VIC_OFF_FLAGS_LOW: rd_mux = pending_flags_low;
      `VIC_OFF_FLAGS_HIGH: rd_mux = pending_flags_high;
      `VIC_OFF_ENABLES_LOW: rd_mux = source_enables_low;
      `VIC_OFF_ENABLES_HIGH: rd_mux = source_enables_high;
      `VIC_OFF_TABLE_BASE: rd_mux = vector_table;
      `VIC_OFF_SPACING: rd_mux = {16'd0, vector_spacing};
      default: begin
        if (prio_hit) begin
          rd_mux = vector_priority[prio_idx];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
    if (paddr[1:0] != 2'b00) begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access & ~pready;
      if (apb_access && !pready) begin
        prdata <= (rd_hit && !pwrite) ? rd_mux : 32'h0000_0000;
        pslverr <= ~rd_hit;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // limitation: no bound check on the table; software must keep
  // base plus last vector times spacing inside its own handler area

endmodule // vic_top

// ### rtl/vic_consts.vh
// register map, field positions and reset values of the vectored interrupt controller
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define VIC_OFF_CONTROL 8'h00
`define VIC_OFF_STATUS 8'h04
`define VIC_OFF_PROX_RELOAD 8'h08
`define VIC_OFF_PROX_COUNT 8'h0C
`define VIC_OFF_FLAGS_LOW 8'h10
`define VIC_OFF_FLAGS_HIGH 8'h14
`define VIC_OFF_ENABLES_LOW 8'h20
`define VIC_OFF_ENABLES_HIGH 8'h24
`define VIC_OFF_PRIO_BASE 8'h30
`define VIC_OFF_PRIO_LAST 8'h58
`define VIC_OFF_TABLE_BASE 8'h60
`define VIC_OFF_SPACING 8'h64

// ----------------------------------------
// field positions
// ----------------------------------------
`define VIC_CTL_MULTI_BIT 12
`define VIC_CTL_PROX_HI 10
`define VIC_CTL_PROX_LO 8
`define VIC_CTL_POL_HI 4
`define VIC_STAT_LEVEL_HI 10
`define VIC_STAT_LEVEL_LO 8
`define VIC_PRIO_FIELD_MASK 32'h1F1F_1F1F

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define VIC_NUM_SOURCES 64
`define VIC_NUM_VECTORS 44
`define VIC_NUM_PRIO_WORDS 11
`define VIC_NUM_EXT 5
`define VIC_RESET_WORD 32'h0000_0000
`define VIC_RESET_SPACING 16'h0020

`endif

// ### rtl/vic_edge_detect.v
// external interrupt pin synchroniser and polarity-selected edge detector
`timescale 1ns/100ps
module vic_edge_detect #(
  parameter N = 5
) (
  input wire pclk,
  input wire presetn,
  input wire [N-1:0] pin,
  input wire [N-1:0] rising_sel,
  output wire [N-1:0] edge_pulse
);

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_pin
      reg meta;
      reg sync;
      reg prev;
      // two flops before any logic; the third holds the last level for edge compare
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta <= 1'b0;
          sync <= 1'b0;
          prev <= 1'b0;
        end else begin
          meta <= pin[i];
          sync <= meta;
          prev <= sync;
        end
      end
      // polarity 1 picks rising, 0 picks falling
      assign edge_pulse[i] = rising_sel[i] ? (sync & ~prev) : (~sync & prev); // [RULE23]
    end
  endgenerate

endmodule // vic_edge_detect

// ### rtl/vic_arbiter.v
// source to vector mapping and priority ranking across all sources
`timescale 1ns/100ps
module vic_arbiter (
  input wire [63:0] pending,
  input wire [63:0] enable,
  input wire [351:0] prio_flat,
  output reg found,
  output reg [5:0] win_vector,
  output reg [2:0] win_level,
  output reg [1:0] win_sub
);

  // vector of each request, several requests fold onto one vector
  function [5:0] vec_of;
    input [5:0] n;
    reg [5:0] g;
    reg [5:0] t;
    begin
      g = (n - 6'd4) / 6'd5;
      t = (n - 6'd4) % 6'd5;
      if (n < 6'd4) vec_of = n;
      else if (n < 6'd29) vec_of = 6'd4 + (g << 2) + ((t == 6'd0) ? 6'd0 : (t <= 6'd2) ? 6'd1 : t - 6'd1); // [RULE14] [RULE17]
      else if (n < 6'd36) vec_of = n - 6'd5;
      else if (n < 6'd48) vec_of = 6'd31 + (n - 6'd36) / 6'd3; // [RULE15] [RULE16]
      else if (n < 6'd50) vec_of = 6'd35;
      else if (n < 6'd59) vec_of = 6'd36 + (n - 6'd50) / 6'd3;
      else if (n < 6'd60) vec_of = 6'd39;
      else vec_of = n - 6'd20; // [RULE19]
    end
  endfunction

  integer i;
  reg [5:0] v;
  reg [4:0] fld;
  // strict greater-than keeps the lower request on a full tie
  always @* begin
    found = 1'b0;
    win_vector = 6'd0;
    win_level = 3'd0;
    win_sub = 2'd0;
    v = 6'd0;
    fld = 5'd0;
    for (i = 0; i < 64; i = i + 1) begin
      v = vec_of(i[5:0]); // [RULE3]
      fld = prio_flat[v*8 +: 5]; // [RULE13]
      if (pending[i] && enable[i] && fld[4:2] != 3'd0) begin // [RULE25]
        if (!found || {fld[4:2], fld[1:0]} > {win_level, win_sub}) begin // [RULE1] [RULE7] [RULE11]
          found = 1'b1;
          win_vector = v;
          win_level = fld[4:2]; // [RULE6]
          win_sub = fld[1:0];
        end
      end
    end
  end

endmodule // vic_arbiter

// ### sim/vic_chk.sv
// port-level assertion checker for the vectored interrupt controller
`timescale 1ns/100ps
module vic_chk #(
  parameter NSRC = 64,
  parameter NEXT = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [NSRC-1:0] src_event,
  input wire [NEXT-1:0] external_irq,
  input wire irq_req,
  input wire [5:0] irq_vector,
  input wire [2:0] irq_level,
  input wire [31:0] irq_handler_addr
);
  // ------
  // shadow of the presentation setup
  // ------
  reg multi;
  reg [31:0] base;
  reg [15:0] spacing;
  reg [3:0] age;
  wire wr_ok = psel & penable & pready & pwrite & ~pslverr;

  function automatic logic mapped(input [7:0] a);
    mapped = a[1:0] == 2'b00 && (a <= 8'h14 || a == 8'h20 || a == 8'h24 ||
             (a >= 8'h30 && a <= 8'h58) || a == 8'h60 || a == 8'h64);
  endfunction

  // age lets the registered outputs catch up after a setup write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multi <= 1'b0;
      base <= 32'h0000_0000;
      spacing <= 16'h0020;
      age <= 4'h0;
    end else if (wr_ok && (paddr == 8'h00 || paddr == 8'h60 || paddr == 8'h64)) begin
      if (paddr == 8'h00) multi <= pwdata[12];
      if (paddr == 8'h60) base <= pwdata;
      if (paddr == 8'h64) spacing <= pwdata[15:0];
      age <= 4'h0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end

  // ------
  // assertions
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wait_state_a: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("pready not one cycle after access start");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero while idle");
  unmapped_err_a: assert property (pready |-> pslverr == !mapped(paddr))
    else $error("pslverr does not match address map");
  level_nonzero_a: assert property (irq_req |-> irq_level != 3'h0)
    else $error("request presented at level zero");
  vector_range_a: assert property (irq_req |-> irq_vector <= 6'd43)
    else $error("vector beyond last");
  single_vec_a: assert property (!multi && age == 4'hF && irq_req |-> irq_vector == 6'd0 && irq_handler_addr == base)
    else $error("single mode vector or address wrong");
  handler_addr_a: assert property (multi && age == 4'hF && irq_req |-> irq_handler_addr == base + irq_vector * spacing)
    else $error("handler address not base plus vector times spacing");

  multi_irq_c: cover property (multi && irq_req);
  single_irq_c: cover property (!multi && irq_req);
  bus_err_c: cover property (pslverr);
endmodule // vic_chk

bind vic_top vic_chk #(.NSRC(NSRC), .NEXT(NEXT)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .src_event(src_event), .external_irq(external_irq), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_level(irq_level), .irq_handler_addr(irq_handler_addr));

// ### sim/vic_cpu_model.sv
// processor-side model that takes presented interrupt requests
`timescale 1ns/100ps
module vic_cpu_model (
  input wire pclk,
  input wire presetn,
  input wire irq_req,
  input wire [5:0] irq_vector,
  input wire [2:0] irq_level
);
  reg last_req;
  reg [5:0] seen_vector;
  reg [2:0] seen_level;
  integer taken;
  // the core takes a request when it first appears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_req <= 1'b0;
      seen_vector <= 6'h00;
      seen_level <= 3'h0;
      taken <= 0;
    end else begin
      last_req <= irq_req;
      if (irq_req && !last_req) begin
        seen_vector <= irq_vector;
        seen_level <= irq_level;
        taken <= taken + 1;
      end
    end
  end
endmodule // vic_cpu_model

// ### sim/vic_test.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
`include "vic_consts.vh"
module vic_test;
  reg pclk, presetn, psel, penable, pwrite, perr;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd, base;
  reg [63:0] src_event, flg, ena;
  reg [4:0] external_irq;
  reg [15:0] spc;
  reg [31:0] pw [0:10];
  wire [31:0] prdata, irq_handler_addr;
  wire pready, pslverr, irq_req;
  wire [5:0] irq_vector;
  wire [2:0] irq_level;
  integer fail_count, check_count, i, k, n, bn, bs;
  int vmap [64] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 8, 9, 9, 10, 11, 12, 13, 13, 14, 15, 16, 17, 17, 18, 19, 20,
    21, 21, 22, 23, 24, 25, 26, 27, 28, 29, 30, 31, 31, 31, 32, 32, 32, 33, 33, 33, 34, 34, 34, 35, 35,
    36, 36, 36, 37, 37, 37, 38, 38, 38, 39, 40, 41, 42, 43};
  int pin_req [5] = '{3, 8, 13, 18, 23};

  vic_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .external_irq(external_irq), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level), .irq_handler_addr(irq_handler_addr));
  vic_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ------
  // shared tasks
  // ------
  task check(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one apb transfer; the request stands until pready is seen
  task apb(input bit w, input [7:0] a, input [31:0] d);
    integer t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t = t + 1;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) begin
      fail_count = fail_count + 1;
      print_verdict;
    end
    @(posedge pclk);
  endtask

  task rdc(input [7:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task rdflags;
    rdc(`VIC_OFF_FLAGS_LOW, flg[31:0]);
    rdc(`VIC_OFF_FLAGS_HIGH, flg[63:32]);
  endtask

  task setup_words;
    apb(1'b1, `VIC_OFF_FLAGS_LOW, flg[31:0]);
    apb(1'b1, `VIC_OFF_FLAGS_HIGH, flg[63:32]);
    apb(1'b1, `VIC_OFF_ENABLES_LOW, ena[31:0]);
    apb(1'b1, `VIC_OFF_ENABLES_HIGH, ena[63:32]);
    repeat (4) @(posedge pclk);
  endtask

  // reference ranking: higher priority, then subpriority, then lower request
  task expect_irq(input bit multi);
    reg [4:0] f;
    integer s;
    bn = -1;
    bs = -1;
    for (n = 0; n < 64; n++) begin
      f = pw[vmap[n] / 4][8 * (vmap[n] % 4) +: 5];
      s = f[4:2] * 4 + f[1:0];
      if (flg[n] && ena[n] && f[4:2] != 3'h0 && s > bs) begin
        bn = n;
        bs = s;
      end
    end
    check(irq_req, bn >= 0);
    if (bn >= 0) begin
      check(irq_level, bs / 4);
      check(irq_vector, multi ? vmap[bn] : 0);
      check(irq_handler_addr, multi ? base + vmap[bn] * spc : base);
    end
  endtask

  // ------
  // main sequence
  // ------
  initial begin
    fail_count = 0;
    check_count = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, src_event, external_irq} = 0;
    rd = $urandom(32'h4dae_52cc);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values over the whole map, holes must be refused
    for (k = 0; k < 8'h6C; k = k + 2) begin
      apb(1'b0, k[7:0], 32'h0000_0000);
      check(perr, !(k inside {[0:20], 32, 36, [48:88], 96, 100}) || k[1]);
      if (!perr) check(rd, k == 8'h64 ? 32'h0000_0020 : 32'h0000_0000);
    end
    apb(1'b1, `VIC_OFF_STATUS, 32'hFFFF_FFFF);
    rdc(`VIC_OFF_STATUS, 32'h0000_0000);
    // a misaligned write inside the priority range is refused and lands nowhere
    apb(1'b1, 8'h32, 32'hFFFF_FFFF);
    check(perr, 1'b1);
    rdc(`VIC_OFF_PRIO_BASE, 32'h0000_0000);
    $display("register map test done");
    // random ranking in multi-vector mode
    base = $urandom;
    spc = $urandom;
    apb(1'b1, `VIC_OFF_TABLE_BASE, base);
    apb(1'b1, `VIC_OFF_SPACING, {16'h0000, spc});
    apb(1'b1, `VIC_OFF_CONTROL, 32'h0000_1000);
    for (i = 0; i < 30; i++) begin
      for (k = 0; k < 11; k++) begin
        pw[k] = $urandom & (i[0] ? `VIC_PRIO_FIELD_MASK : 32'h0404_0404);
        apb(1'b1, `VIC_OFF_PRIO_BASE + 4 * k, $urandom);
        apb(1'b1, `VIC_OFF_PRIO_BASE + 4 * k, pw[k]);
        rdc(`VIC_OFF_PRIO_BASE + 4 * k, pw[k]);
      end
      flg = {$urandom, $urandom} & {$urandom, $urandom};
      ena = {$urandom, $urandom};
      setup_words;
      expect_irq(1'b1);
      rdflags;
    end
    $display("ranking test done");
    // hardware events set flags that stay until cleared
    flg = 0;
    ena = {64{1'b1}};
    setup_words;
    for (i = 0; i < 10; i++) begin
      do n = $urandom % 64; while (n inside {3, 8, 13, 18, 23});
      src_event[n] <= 1'b1;
      @(posedge pclk);
      src_event[n] <= 1'b0;
      repeat (3) @(posedge pclk);
      flg[n] = 1'b1;
      rdflags;
    end
    expect_irq(1'b1);
    src_event[n] <= 1'b1;
    apb(1'b1, n < 32 ? `VIC_OFF_FLAGS_LOW : `VIC_OFF_FLAGS_HIGH, 32'h0000_0000);
    flg[63:32] = n < 32 ? flg[63:32] : 32'h0000_0000;
    flg[31:0] = n < 32 ? 32'h0000_0000 : flg[31:0];
    flg[n] = 1'b1;
    rdflags;
    src_event[n] <= 1'b0;
    $display("event test done");
    // each pin: wrong edge ignored, selected edge sets its request
    for (k = 0; k < 10; k++) begin
      i = k / 2;
      apb(1'b1, `VIC_OFF_CONTROL, 32'h0000_1000 | (k[0] << i));
      // park the pin where the ignored edge starts, clear, then make that edge
      external_irq[i] <= k[0];
      repeat (6) @(posedge pclk);
      flg = 0;
      setup_words;
      external_irq[i] <= ~k[0];
      repeat (6) @(posedge pclk);
      rdflags;
      external_irq[i] <= k[0];
      repeat (6) @(posedge pclk);
      flg[pin_req[i]] = 1'b1;
      rdflags;
    end
    $display("pin test done");
    // proximity hold: a level-7 winner waits out a reload of 40 cycles
    pw[0] = 32'h0000_001C;
    apb(1'b1, `VIC_OFF_PRIO_BASE, pw[0]);
    apb(1'b1, `VIC_OFF_PROX_RELOAD, 32'h0000_0028);
    apb(1'b1, `VIC_OFF_CONTROL, 32'h0000_1700);
    flg = 0;
    setup_words;
    src_event[0] <= 1'b1;
    @(posedge pclk);
    src_event[0] <= 1'b0;
    flg[0] = 1'b1;
    repeat (20) @(posedge pclk);
    check(irq_req, 1'b0);
    repeat (30) @(posedge pclk);
    expect_irq(1'b1);
    $display("proximity test done");
    // single-vector mode shows vector zero, status keeps the real one
    apb(1'b1, `VIC_OFF_CONTROL, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      flg = {$urandom, $urandom};
      setup_words;
      expect_irq(1'b0);
      if (bn >= 0) rdc(`VIC_OFF_STATUS, ((bs / 4) << 8) | vmap[bn]);
    end
    check(i_cpu.taken > 0, 1'b1);
    $display("single mode test done");
    print_verdict;
  end
endmodule // vic_test
